// File: rtl/clkgen_pkg.sv
// Purpose: shared constants and types for the clock generator control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: register bytes sit in the low bits of each word, upper bits read zero
package clkgen_pkg;

  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_STAT_A = 8'h08;
  localparam logic [7:0] OFS_STAT_B = 8'h0C;
  localparam logic [7:0] OFS_FILTER = 8'h10;

  // control a fields
  localparam int HGO_BIT = 7;
  localparam int RANGE_BIT = 6;
  localparam int EXT_REF_KIND_SELECT_BIT = 5;
  localparam int MODE_HI = 4;
  localparam int MODE_LO = 3;
  localparam int OSCKEEP_BIT = 2;
  localparam int LOSSOFF_BIT = 1;
  // control b fields
  localparam int LOLRST_BIT = 7;
  localparam int MULT_HI = 6;
  localparam int MULT_LO = 4;
  localparam int LOCRST_BIT = 3;
  localparam int DIV_HI = 2;
  localparam int DIV_LO = 0;
  // status a write-one-to-clear bit
  localparam int IRQCLR_BIT = 0;

  // async input channels
  localparam int NUM_PINS = 4;
  localparam int PIN_EXT_REF_CLOCK_OK = 0;
  localparam int PIN_OSC_OUTPUT_STABLE = 1;
  localparam int PIN_LOL = 2;
  localparam int PIN_LOC = 3;

  localparam logic [6:0] PRESCALE_LOW = 7'h40;
  localparam logic [6:0] PRESCALE_HIGH = 7'h01;
  localparam logic [6:0] PRESCALE_INT = 7'h40;
  localparam logic [4:0] MULT_BASE = 5'h04;
  localparam int FILT_W = 12;

  localparam int CLK_PERIOD_NS = 50;
  localparam int MODE_SETTLE_NS = 200;
  localparam int MODE_SETTLE_CYC = (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_SCM = 2'b00,
    MODE_FEI = 2'b01,
    MODE_FBE = 2'b10,
    MODE_FEE = 2'b11
  } clk_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    clk_mode_t mode;
    logic high_gain_select;
    logic range_high;
    logic ext_ref_kind_select;
    logic osc_keep_in_stop;
    logic [10:0] eff_mult;
    logic [2:0] reduce_divide_code;
    logic [FILT_W-1:0] loop_filter_bits;
  } clk_cfg_t;

endpackage : clkgen_pkg

// File: rtl/internal_clock_generator_control.sv
// Purpose: control and status of an on-chip clock generator, APB register slave
// Assumes: pins async to pclk; loop_filter_auto comes from the loop on pclk
// Notes: frequencies are reported in kHz from parameterised reference figures
// What this block does
// - high gain bit chooses low power or high gain; only first write counts.
// - range bit selects prescale 64 when low, 1 when high; write-once.
// - range affects behaviour only in loop-engaged or bypassed external modes.
// - write-once reference kind bit: 0 external clock, 1 crystal oscillator.
// - mode field decodes self-clocked, internal loop, external bypass, external loop.
// - external bypass mode is not entered until external reference flag is one.
// - generator off mode leaves the mode field unchanged.
// - mode field write ignored while a previous mode change is incomplete.
// - first mode write of 0X blocks later 1X writes until reset.
// - after reset the generator is self-clocked near 8 MHz, bus half that.
// - lock loss raises interrupt request unless lock loss reset is enabled.
// - clock loss raises interrupt request unless clock loss reset is enabled.
// - multiply factor equals four plus twice the code, 4 to 18.
// - output divided by two to the power of the divide code.
// - first status register is read-only except writing to clear interrupt flag.
// - filter value matters only self-clocked; loop modes adjust it; top four bits unused.
// - bit 0 of first control register always reads zero.
// - high gain bit at zero configures oscillator for low power.
//
// Our own choices: the address map and the APB register port.
module internal_clock_generator_control import clkgen_pkg::*; #(
  parameter int SCM_KHZ = 8000,
  parameter int INT_REF_KHZ = 32,
  parameter int EXT_REF_KHZ = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  input wire logic [NUM_PINS-1:0] async_pins,
  input wire logic gen_off_mode,
  input wire logic [FILT_W-1:0] loop_filter_auto,
  output clk_cfg_t clk_cfg,
  output logic [31:0] gen_out_khz,
  output logic [31:0] bus_khz,
  output logic gen_irq,
  output logic gen_reset_req
);

  typedef struct packed {
    apb_rsp_t rsp;
    clk_cfg_t cfg;
    logic ctrl_a_locked;
    clk_mode_t mode_sel;
    logic loss_det_off;
    logic lock_rst_en;
    logic [2:0] mult_code;
    logic clk_rst_en;
    logic mode_written;
    logic ext_pin_reserved;
    logic pending;
    clk_mode_t target;
    logic [2:0] settle;
    logic [NUM_PINS-1:0][2:0] sync;
    logic [NUM_PINS-1:0] filt;
    logic lock_flag;
    logic clock_flag;
    logic irq_flag;
    logic reset_req;
    logic [31:0] out_khz;
    logic [31:0] bus_khz;
  } state_t;

  localparam logic [2:0] SETTLE_LAST = 3'(MODE_SETTLE_CYC - 1);

  state_t r_q;
  state_t r_d;
  logic wr;
  logic rd_setup;
  logic wr_ctrl_a;
  logic clock_mode_select_ok;
  logic lock_ev;
  logic clock_ev;
  logic [NUM_PINS-1:0] rise;
  logic [4:0] mult_n;
  logic [6:0] prescale;
  logic [31:0] base_khz;
  logic [7:0] rbyte;
  logic mapped;

  assign apb_rsp = r_q.rsp;
  assign clk_cfg = r_q.cfg;
  assign gen_out_khz = r_q.out_khz;
  assign bus_khz = r_q.bus_khz;
  assign gen_irq = r_q.irq_flag;
  assign gen_reset_req = r_q.reset_req;

  always_comb begin
    r_d = r_q;
    rise = '0;
    rbyte = 8'h00;
    mapped = 1'b1;
    base_khz = 32'h0;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite & r_q.rsp.pready;
    rd_setup = apb_req.psel & ~apb_req.penable;
    wr_ctrl_a = wr & (apb_req.paddr == OFS_CTRL_A);

    // three-stage synchronisers; a level counts once stages two and three agree
    for (int i = 0; i < NUM_PINS; i++) begin
      r_d.sync[i] = {r_q.sync[i][1:0], async_pins[i]};
      if (r_q.sync[i][1] == r_q.sync[i][2]) begin
        r_d.filt[i] = r_q.sync[i][2];
        rise[i] = r_q.sync[i][2] & ~r_q.filt[i];
      end
    end

    // apb: answer comes in the access cycle right after setup
    r_d.rsp.pready = rd_setup;
    case (apb_req.paddr)
      OFS_CTRL_A: rbyte = {r_q.cfg.high_gain_select, r_q.cfg.range_high, r_q.cfg.ext_ref_kind_select,
                           r_q.mode_sel, r_q.cfg.osc_keep_in_stop, r_q.loss_det_off, 1'b0};
      OFS_CTRL_B: rbyte = {r_q.lock_rst_en, r_q.mult_code, r_q.clk_rst_en, r_q.cfg.reduce_divide_code};
      OFS_STAT_A: rbyte = {r_q.cfg.mode, r_q.filt[PIN_EXT_REF_CLOCK_OK], r_q.lock_flag, ~r_q.filt[PIN_LOL],
                           r_q.clock_flag, 1'b0, r_q.irq_flag};
      OFS_STAT_B: rbyte = {7'h00, r_q.filt[PIN_OSC_OUTPUT_STABLE]};
      OFS_FILTER: rbyte = 8'h00;
      default: mapped = 1'b0;
    endcase
    if (rd_setup) begin
      r_d.rsp.pslverr = ~mapped;
      r_d.rsp.prdata = {24'h000000, rbyte};
      if (apb_req.paddr == OFS_FILTER) begin
        r_d.rsp.prdata = {20'h00000, r_q.cfg.loop_filter_bits};
      end
    end else begin
      r_d.rsp.pslverr = 1'b0;
      r_d.rsp.prdata = 32'h0;
    end

    // write-once oscillator options; osc_keep_in_stop and loss_det_off take every write
    if (wr_ctrl_a && !r_q.ctrl_a_locked) begin
      r_d.ctrl_a_locked = 1'b1;
      r_d.cfg.high_gain_select = apb_req.pwdata[HGO_BIT];
      r_d.cfg.range_high = apb_req.pwdata[RANGE_BIT];
      r_d.cfg.ext_ref_kind_select = apb_req.pwdata[EXT_REF_KIND_SELECT_BIT];
    end
    if (wr_ctrl_a) begin
      r_d.cfg.osc_keep_in_stop = apb_req.pwdata[OSCKEEP_BIT];
      r_d.loss_det_off = apb_req.pwdata[LOSSOFF_BIT];
    end

    // mode field write: refused while busy, or 1X after an unreserved first write
    clock_mode_select_ok = !r_q.pending && !(r_q.mode_written && !r_q.ext_pin_reserved && apb_req.pwdata[MODE_HI]);
    if (wr_ctrl_a && clock_mode_select_ok) begin
      r_d.mode_sel = clk_mode_t'(apb_req.pwdata[MODE_HI:MODE_LO]);
      r_d.target = clk_mode_t'(apb_req.pwdata[MODE_HI:MODE_LO]);
      r_d.pending = 1'b1;
      r_d.settle = 3'h0;
      if (!r_q.mode_written) begin
        r_d.mode_written = 1'b1;
        r_d.ext_pin_reserved = apb_req.pwdata[MODE_HI];
      end
    end else if (r_q.pending && !gen_off_mode) begin
      if (r_q.settle == SETTLE_LAST) begin
        if (r_q.target != MODE_FBE || r_q.filt[PIN_EXT_REF_CLOCK_OK]) begin
          r_d.cfg.mode = r_q.target;
          r_d.pending = 1'b0;
        end
      end else begin
        r_d.settle = r_q.settle + 3'h1;
      end
    end

    if (wr && apb_req.paddr == OFS_CTRL_B) begin
      r_d.lock_rst_en = apb_req.pwdata[LOLRST_BIT];
      r_d.mult_code = apb_req.pwdata[MULT_HI:MULT_LO];
      r_d.clk_rst_en = apb_req.pwdata[LOCRST_BIT];
      r_d.cfg.reduce_divide_code = apb_req.pwdata[DIV_HI:DIV_LO];
    end

    // filter: software value in self-clocked mode, loop value when loop engaged
    if (r_q.cfg.mode == MODE_SCM) begin
      if (wr && apb_req.paddr == OFS_FILTER) begin
        r_d.cfg.loop_filter_bits = apb_req.pwdata[FILT_W-1:0];
      end
    end else if (r_q.cfg.mode != MODE_FBE) begin
      r_d.cfg.loop_filter_bits = loop_filter_auto;
    end

    // loss events; a write of one to the clear bit loses to a same-cycle event
    lock_ev = rise[PIN_LOL] && (r_q.cfg.mode == MODE_FEI || r_q.cfg.mode == MODE_FEE);
    clock_ev = rise[PIN_LOC] && !r_q.loss_det_off && r_q.cfg.mode[1];
    if (wr && apb_req.paddr == OFS_STAT_A && apb_req.pwdata[IRQCLR_BIT]) begin
      r_d.irq_flag = 1'b0;
      r_d.lock_flag = 1'b0;
      r_d.clock_flag = 1'b0;
    end
    r_d.reset_req = (lock_ev && r_q.lock_rst_en) || (clock_ev && r_q.clk_rst_en);
    if (lock_ev && !r_q.lock_rst_en) begin
      r_d.lock_flag = 1'b1;
      r_d.irq_flag = 1'b1;
    end
    if (clock_ev && !r_q.clk_rst_en) begin
      r_d.clock_flag = 1'b1;
      r_d.irq_flag = 1'b1;
    end

    // frequency plan from the active mode
    mult_n = MULT_BASE + {1'b0, r_q.mult_code, 1'b0};
    if (r_q.cfg.mode[1]) begin
      prescale = r_q.cfg.range_high ? PRESCALE_HIGH : PRESCALE_LOW;
    end else begin
      prescale = PRESCALE_INT;
    end
    r_d.cfg.eff_mult = 11'({4'h0, prescale} * {6'h00, mult_n});
    case (r_q.cfg.mode)
      MODE_SCM: base_khz = 32'(SCM_KHZ);
      MODE_FEI: base_khz = 32'({21'h0, r_q.cfg.eff_mult} * 32'(INT_REF_KHZ));
      MODE_FBE: base_khz = 32'(EXT_REF_KHZ);
      MODE_FEE: base_khz = 32'({21'h0, r_q.cfg.eff_mult} * 32'(EXT_REF_KHZ));
      default: base_khz = 32'(SCM_KHZ);
    endcase
    r_d.out_khz = base_khz >> r_q.cfg.reduce_divide_code;
    r_d.bus_khz = r_q.out_khz >> 1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_accept_fast;
    wr_ctrl_a && clock_mode_select_ok && apb_req.pwdata[MODE_HI:MODE_LO] != MODE_FBE;
  endsequence

  sequence s_run_on;
    !gen_off_mode [*5];
  endsequence

  sequence s_lock_irq;
    lock_ev && !r_q.lock_rst_en;
  endsequence

  a_mode_reset_scm: assert property (
    !r_q.mode_written |-> r_q.cfg.mode == MODE_SCM)
    else $error("mode left self-clocked without a write");

  // the first edge after release still shows the reset value, so look one edge further
  a_scm_out_freq: assert property (
    $past(presetn) && !r_q.mode_written && $past(r_q.cfg.reduce_divide_code) == 3'h0
      |-> r_q.out_khz == 32'(SCM_KHZ))
    else $error("self-clocked output frequency wrong after reset");

  a_bus_half: assert property (
    $past(presetn) |-> r_q.bus_khz == $past(r_q.out_khz) >> 1)
    else $error("bus frequency is not half the output");

  a_bypass_waits_ext_ref_clock_ok: assert property (
    r_q.cfg.mode == MODE_FBE && $past(r_q.cfg.mode) != MODE_FBE |-> $past(r_q.filt[PIN_EXT_REF_CLOCK_OK]))
    else $error("bypass mode entered without external reference");

  a_busy_write_ignored: assert property (
    wr_ctrl_a && r_q.pending |=> r_q.mode_sel == $past(r_q.mode_sel))
    else $error("mode field changed while busy");

  a_ext_write_refused: assert property (
    wr_ctrl_a && r_q.mode_written && !r_q.ext_pin_reserved |=> !r_q.mode_sel[1])
    else $error("1X mode accepted after unreserved first write");

  a_osc_opts_once: assert property (
    wr_ctrl_a && r_q.ctrl_a_locked |=> $stable(r_q.cfg.high_gain_select) && $stable(r_q.cfg.range_high)
      && $stable(r_q.cfg.ext_ref_kind_select))
    else $error("write-once option changed");

  a_off_holds_mode: assert property (
    gen_off_mode && !wr |=> $stable(r_q.mode_sel) && $stable(r_q.cfg.mode))
    else $error("mode changed in off mode");

  a_mode_settles: assert property (
    s_accept_fast ##1 s_run_on |-> !r_q.pending)
    else $error("mode change did not complete in time");

  a_lock_loss_irq: assert property (
    s_lock_irq |=> r_q.irq_flag && r_q.lock_flag && !r_q.reset_req)
    else $error("lock loss did not raise interrupt");

  a_clock_loss_irq: assert property (
    clock_ev && !r_q.clk_rst_en |=> r_q.irq_flag && r_q.clock_flag && !r_q.reset_req)
    else $error("clock loss did not raise interrupt");

  a_mult_map: assert property (
    r_q.cfg.mode == MODE_FEE && $stable(r_q.mult_code) && $stable(r_q.cfg.range_high) && $stable(r_q.cfg.mode)
      |-> r_q.cfg.eff_mult == (r_q.cfg.range_high ? 11'h001 : 11'h040) * (11'h004 + 11'(r_q.mult_code) * 11'h002))
    else $error("multiply factor mismatch");

  a_bit0_reads_zero: assert property (
    rd_setup && apb_req.paddr == OFS_CTRL_A |=> r_q.rsp.pready && !r_q.rsp.prdata[0])
    else $error("control a bit 0 read as one");

  a_status_clear: assert property (
    wr && apb_req.paddr == OFS_STAT_A && apb_req.pwdata[IRQCLR_BIT] && !lock_ev && !clock_ev |=> !r_q.irq_flag)
    else $error("interrupt flag not cleared");

  a_status_write_keeps_mode: assert property (
    wr && apb_req.paddr == OFS_STAT_A && !r_q.pending |=> $stable(r_q.cfg.mode) && $stable(r_q.mode_sel))
    else $error("status write changed the mode");

  a_scm_divide: assert property (
    $past(presetn) && $past(r_q.cfg.mode) == MODE_SCM
      |-> r_q.out_khz == 32'(SCM_KHZ) >> $past(r_q.cfg.reduce_divide_code))
    else $error("self-clocked output not divided by two to the code");

  a_int_loop_freq: assert property (
    $past(presetn) && $past(r_q.cfg.mode) == MODE_FEI
      |-> r_q.out_khz == (32'($past(r_q.cfg.eff_mult)) * 32'(INT_REF_KHZ)) >> $past(r_q.cfg.reduce_divide_code))
    else $error("internal loop output frequency wrong");

  a_bypass_freq: assert property (
    $past(presetn) && $past(r_q.cfg.mode) == MODE_FBE
      |-> r_q.out_khz == 32'(EXT_REF_KHZ) >> $past(r_q.cfg.reduce_divide_code))
    else $error("bypass output frequency wrong");

  a_ext_loop_freq: assert property (
    $past(presetn) && $past(r_q.cfg.mode) == MODE_FEE
      |-> r_q.out_khz == (32'($past(r_q.cfg.eff_mult)) * 32'(EXT_REF_KHZ)) >> $past(r_q.cfg.reduce_divide_code))
    else $error("external loop output frequency wrong");

  // internal modes ignore the range bit and always use the low-range prescale
  a_internal_prescale: assert property (
    r_q.cfg.mode == MODE_FEI && $stable(r_q.cfg.mode) && $stable(r_q.mult_code)
      |-> r_q.cfg.eff_mult == 11'h040 * (11'h004 + 11'(r_q.mult_code) * 11'h002))
    else $error("internal mode prescale wrong");

  a_filter_tracks_loop: assert property (
    $past(presetn) && ($past(r_q.cfg.mode) == MODE_FEI || $past(r_q.cfg.mode) == MODE_FEE)
      |-> r_q.cfg.loop_filter_bits == $past(loop_filter_auto))
    else $error("filter does not follow the loop");

  a_filter_write_scm: assert property (
    wr && apb_req.paddr == OFS_FILTER && r_q.cfg.mode == MODE_SCM
      |=> r_q.cfg.loop_filter_bits == $past(apb_req.pwdata[FILT_W-1:0]))
    else $error("filter write lost in self-clocked mode");

  a_filter_top_zero: assert property (
    rd_setup && apb_req.paddr == OFS_FILTER |=> r_q.rsp.prdata[31:FILT_W] == '0)
    else $error("unused filter bits read as one");

  a_first_opts_land: assert property (
    wr_ctrl_a && !r_q.ctrl_a_locked |=> r_q.cfg.ext_ref_kind_select == $past(apb_req.pwdata[EXT_REF_KIND_SELECT_BIT])
      && r_q.cfg.range_high == $past(apb_req.pwdata[RANGE_BIT]))
    else $error("first option write not taken");

  a_low_power_default: assert property (
    !r_q.ctrl_a_locked |-> !r_q.cfg.high_gain_select)
    else $error("oscillator not low power before first write");

  a_pin_reserved: assert property (
    wr_ctrl_a && !r_q.mode_written |=> r_q.ext_pin_reserved == $past(apb_req.pwdata[MODE_HI]))
    else $error("external pin reservation wrong");

  a_mode_write_taken: assert property (
    wr_ctrl_a && !r_q.pending && (r_q.ext_pin_reserved || !r_q.mode_written)
      |=> r_q.mode_sel == $past(apb_req.pwdata[MODE_HI:MODE_LO]))
    else $error("allowed mode write not taken");

  a_lock_loss_reset: assert property (
    lock_ev && r_q.lock_rst_en |=> r_q.reset_req)
    else $error("lock loss did not request reset");

  a_stable_readback: assert property (
    rd_setup && apb_req.paddr == OFS_STAT_B |=> r_q.rsp.prdata == {31'h00000000, $past(r_q.filt[PIN_OSC_OUTPUT_STABLE])})
    else $error("oscillator stable flag read wrong");

endmodule : internal_clock_generator_control

// File: verif/clock_source_model.sv
// Purpose: far-side model of the reference source feeding the status pins
// Assumes: start rises once the crystal or external clock is powered
// Notes: LAG sets how slowly the reference becomes usable
module clock_source_model #(
  parameter int LAG = 20
) (
  input wire logic pclk,
  input wire logic start,
  input wire logic [1:0] fault,
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_q = 6'h00;
  always @(posedge pclk) begin
    cnt_q <= !start ? 6'h00 : (cnt_q == 6'h3F ? cnt_q : cnt_q + 6'h01);
  end
  // reference ok first, oscillator stable a few cycles later
  assign pins = {fault[1], fault[0], cnt_q >= 6'(LAG + 4), cnt_q >= 6'(LAG)};
endmodule : clock_source_model

// File: verif/internal_clock_generator_control_test.sv
// Purpose: self-checking bench for the clock generator control block
// Assumes: source model drives the reference status pins
// Notes: divide codes and filter values drawn from a fixed seed
module internal_clock_generator_control_test import clkgen_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic gen_off_mode = 1'b0;
  logic src_start = 1'b0;
  logic [1:0] fault = 2'h0;
  logic [FILT_W-1:0] filt_auto = '0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  clk_cfg_t cfg;
  logic [3:0] pins;
  logic [31:0] out_khz, bus_khz, rdata;
  logic irq, rst_req, perr, seen;
  logic [2:0] d;
  int errors = 0;
  int n_compared = 0;
  internal_clock_generator_control i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .async_pins(pins), .gen_off_mode(gen_off_mode), .loop_filter_auto(filt_auto), .clk_cfg(cfg),
    .gen_out_khz(out_khz), .bus_khz(bus_khz), .gen_irq(irq), .gen_reset_req(rst_req));
  clock_source_model i_src (.pclk(pclk), .start(src_start), .fault(fault), .pins(pins));
  initial begin
    forever #25 pclk = ~pclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic results;
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    perr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic mode_is(input logic [1:0] m);
    apb(1'b0, OFS_STAT_A, 32'h0);
    chk(32'(rdata[7:6]), 32'(m));
  endtask : mode_is
  task automatic rst;
    presetn <= 1'b0;
    src_start <= 1'b0;
    fault <= 2'h0;
    tick(8);
    presetn <= 1'b1;
    tick(3);
  endtask : rst
  function automatic logic [31:0] exp_khz(input logic [1:0] md, input logic rg, input logic [2:0] m,
                                          input logic [2:0] dv);
    logic [31:0] p;
    p = (md == 2'b11 && rg) ? 32'h1 : 32'h40;
    case (md)
      2'b00: return 32'h1F40 >> dv;
      2'b10: return 32'h20 >> dv;
      default: return (32'h20 * p * (32'h4 + 32'h2 * m)) >> dv;
    endcase
  endfunction : exp_khz
  initial begin
    tick(20000);
    errors++;
    results();
  end
  initial begin
    void'($urandom(40584));
    rst();
    chk(out_khz, 32'h1F40);
    chk(bus_khz, 32'hFA0);
    apb(1'b1, OFS_CTRL_A, 32'h09);
    tick(6);
    apb(1'b0, OFS_CTRL_A, 32'h0);
    chk(rdata, 32'h08);
    chk(32'(cfg.high_gain_select), 32'h0);
    apb(1'b1, OFS_CTRL_A, 32'hF0);
    tick(6);
    apb(1'b0, OFS_CTRL_A, 32'h0);
    chk(rdata, 32'h08);
    chk(32'(cfg.high_gain_select), 32'h0);
    mode_is(2'b01);
    for (int i = 0; i < 8; i++) begin
      d = 3'($urandom);
      apb(1'b1, OFS_CTRL_B, {24'h0, 1'b0, i[2:0], 1'b0, d});
      tick(4);
      chk(32'(cfg.eff_mult), 32'h40 * (32'h4 + 32'h2 * i));
      chk(out_khz, exp_khz(2'b01, 1'b0, i[2:0], d));
      chk(bus_khz, exp_khz(2'b01, 1'b0, i[2:0], d) >> 1);
    end
    filt_auto <= FILT_W'($urandom);
    tick(3);
    chk(32'(cfg.loop_filter_bits), 32'(filt_auto));
    // second mode write lands while the first is still settling
    apb(1'b1, OFS_CTRL_A, 32'h00);
    apb(1'b1, OFS_CTRL_A, 32'h08);
    tick(8);
    mode_is(2'b00);
    apb(1'b1, OFS_FILTER, 32'hFFFF);
    apb(1'b0, OFS_FILTER, 32'h0);
    chk(rdata, 32'hFFF);
    gen_off_mode <= 1'b1;
    apb(1'b1, OFS_CTRL_A, 32'h08);
    tick(8);
    mode_is(2'b00);
    gen_off_mode <= 1'b0;
    tick(8);
    mode_is(2'b01);
    fault <= 2'b01;
    tick(8);
    chk(32'(irq), 32'h1);
    fault <= 2'b00;
    tick(6);
    apb(1'b1, OFS_STAT_A, 32'hFF);
    tick(2);
    chk(32'(irq), 32'h0);
    mode_is(2'b01);
    apb(1'b1, OFS_CTRL_B, 32'h80);
    fault <= 2'b01;
    seen = 1'b0;
    repeat (10) begin
      @(posedge pclk);
      seen = seen | rst_req;
    end
    chk(32'(seen), 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(perr), 32'h1);
    rst();
    apb(1'b1, OFS_CTRL_A, 32'h38);
    tick(8);
    chk(32'(cfg.ext_ref_kind_select), 32'h1);
    chk(32'(cfg.eff_mult), 32'h100);
    chk(out_khz, exp_khz(2'b11, 1'b0, 3'h0, 3'h0));
    apb(1'b1, OFS_CTRL_A, 32'h30);
    tick(10);
    mode_is(2'b11);
    src_start <= 1'b1;
    rdata = 32'h0;
    for (int k = 0; k < 40 && rdata[0] !== 1'b1; k++) begin
      apb(1'b0, OFS_STAT_B, 32'h0);
    end
    chk(32'(rdata[0]), 32'h1);
    tick(8);
    mode_is(2'b10);
    chk(out_khz, exp_khz(2'b10, 1'b0, 3'h0, 3'h0));
    fault <= 2'b10;
    tick(8);
    chk(32'(irq), 32'h1);
    rst();
    apb(1'b1, OFS_CTRL_A, 32'h58);
    tick(8);
    chk(32'(cfg.ext_ref_kind_select), 32'h0);
    chk(32'(cfg.range_high), 32'h1);
    chk(32'(cfg.eff_mult), 32'h4);
    apb(1'b1, OFS_CTRL_A, 32'h48);
    tick(8);
    chk(32'(cfg.eff_mult), 32'h100);
    results();
  end
endmodule : internal_clock_generator_control_test
